// ---- inc/tw_pkg.sv ----
// constants and types of the 8-bit waveform timer
package tw_pkg;
  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int TW_ADDR_W = 8;
  localparam logic [7:0] TW_OFF_CTRL = 8'h00;
  localparam logic [7:0] TW_OFF_CLK = 8'h04;
  localparam logic [7:0] TW_OFF_COUNT = 8'h08;
  localparam logic [7:0] TW_OFF_CMPA = 8'h0C;
  localparam logic [7:0] TW_OFF_CMPB = 8'h10;
  localparam logic [7:0] TW_OFF_FLAGS = 8'h14;
  localparam logic [7:0] TW_OFF_PORT = 8'h18;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TW_CTRL_ACTA_LSB = 6;
  localparam int TW_CTRL_ACTB_LSB = 4;
  localparam int TW_CTRL_WGM_LSB = 0;
  localparam int TW_CLK_SEL_LSB = 0;
  localparam int TW_CLK_FORCEA_BIT = 7;
  localparam int TW_CLK_FORCEB_BIT = 6;
  localparam int TW_FLAG_OVF_BIT = 0;
  localparam int TW_FLAG_CMPA_BIT = 1;
  localparam int TW_FLAG_CMPB_BIT = 2;
  localparam int TW_PORT_DIRA_BIT = 0;
  localparam int TW_PORT_DIRB_BIT = 1;
  localparam int TW_PORT_VALA_BIT = 2;
  localparam int TW_PORT_VALB_BIT = 3;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] TW_RST_BYTE = 8'h00;
  localparam logic [7:0] TW_MAX = 8'hFF;
  localparam logic [7:0] TW_BOTTOM = 8'h00;
  localparam logic [9:0] TW_DIV8_MASK = 10'h007;
  localparam logic [9:0] TW_DIV64_MASK = 10'h03F;
  localparam logic [9:0] TW_DIV256_MASK = 10'h0FF;
  localparam logic [9:0] TW_DIV1024_MASK = 10'h3FF;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TW_NORMAL = 3'b000,
    TW_PC_MAX = 3'b001,
    TW_CLR_MATCH = 3'b010,
    TW_FAST_MAX = 3'b011,
    TW_RSV4 = 3'b100,
    TW_PC_A = 3'b101,
    TW_RSV6 = 3'b110,
    TW_FAST_A = 3'b111
  } tw_mode_type;
  typedef enum logic [2:0] {
    TW_CLK_STOP = 3'b000,
    TW_CLK_DIV1 = 3'b001,
    TW_CLK_DIV8 = 3'b010,
    TW_CLK_DIV64 = 3'b011,
    TW_CLK_DIV256 = 3'b100,
    TW_CLK_DIV1024 = 3'b101
  } tw_clksel_type;
endpackage

// ---- core/tw_timer8.sv ----
// 8-bit timer with clear-on-match, single-slope and dual-slope waveform modes
`timescale 1ns/1ps
// How it works
// - waveform select 2 clears the counter when it equals compare A.
// - clear-on-match raises compare A flag at each ceiling reach.
// - clear-on-match writes compare A directly; a low value waits for wrap.
// - clear-on-match with action 1 toggles output A on each match.
// - pin is driven only while its direction bit says output.
// - clear-on-match sets overflow when count passes max to zero.
// - selects 3 and 7 count up to ceiling 0xFF or compare A.
// - single-slope counts to ceiling then clears on next tick.
// - single-slope action 2 clears on match, sets at zero; 3 inverse.
// - single-slope sets overflow each time counter reaches ceiling.
// - single-slope action 1 toggles A only with high select bit; B none.
// - single-slope keeps compare buffering, also for toggled output.
// - zero compare gives one-tick spike; max compare gives steady level.
// - selects 1 and 5 count up then down, ceiling 0xFF or compare A.
// - dual-slope holds ceiling one tick then counts down.
// - dual-slope action 2 clears on up match, sets on down; 3 inverse.
// - dual-slope sets overflow when the counter reaches zero.
// - dual-slope action 1 toggles A only with high select bit; B none.
// - dual-slope zero compare gives low, max gives high; inverted opposite.
// - dual-slope fixes the output at zero to keep it symmetric.
// - timer tick divides the clock by 1, 8, 64, 256 or 1024.
// - action 0 disconnects the output; pin keeps port behaviour.
// - in PWM, compare writes land in a buffer copied at ceiling.
// - a match sets its compare flag on the next timer tick.
module tw_timer8 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [tw_pkg::TW_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // waveform pins
  output logic waveOutA,
  output logic waveOeA,
  output logic waveOutB,
  output logic waveOeB
);
  import tw_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic tw_tick_of(input logic [2:0] sel, input logic [9:0] cnt);
    case (sel)
      TW_CLK_DIV1: tw_tick_of = 1'b1;
      TW_CLK_DIV8: tw_tick_of = (cnt & TW_DIV8_MASK) == TW_DIV8_MASK;
      TW_CLK_DIV64: tw_tick_of = (cnt & TW_DIV64_MASK) == TW_DIV64_MASK;
      TW_CLK_DIV256: tw_tick_of = (cnt & TW_DIV256_MASK) == TW_DIV256_MASK;
      TW_CLK_DIV1024: tw_tick_of = (cnt & TW_DIV1024_MASK) == TW_DIV1024_MASK;
      default: tw_tick_of = 1'b0;
    endcase
  endfunction

  // next level of one waveform output at a timer tick
  function automatic logic tw_wave_step(input logic cur, input logic [1:0] act,
      input logic toggleOk, input logic fast, input logic pc, input logic match,
      input logic up, input logic wrapPt, input logic turnTop, input logic turnBot,
      input logic cmpTop, input logic cmpZero);
    logic r;
    r = cur;
    if (act == 2'd0) begin
      r = cur;
    end else if (!fast && !pc) begin
      if (match) begin
        r = (act == 2'd1) ? ~cur : act[0];
      end
    end else if (act == 2'd1) begin
      if (toggleOk && match) begin
        r = ~cur;
      end
    end else if (fast) begin
      if (wrapPt) begin
        r = ~act[0];
      end
      if (match && !cmpTop) begin
        r = act[0];
      end
    end else begin
      if (match && !cmpTop) begin
        r = up ? act[0] : ~act[0];
      end
      if (turnTop && cmpTop) begin
        r = ~act[0];
      end
      if (turnBot && !cmpZero) begin
        r = ~act[0];
      end
    end
    tw_wave_step = r;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [1:0] actA_q, actB_q;
  logic [2:0] wgm_q, clkSel_q;
  logic [9:0] preCnt_q;
  logic [7:0] count_q, count_d;
  logic dirUp_q, dirUp_d;
  logic [7:0] cmpA_q, cmpB_q, bufA_q, bufB_q;
  logic ovf_q, flagA_q, flagB_q, pendA_q, pendB_q, block_q;
  logic waveA_q, waveB_q;
  logic [1:0] dir_q, portVal_q;
  logic [7:0] rdData_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic tick = tw_tick_of(clkSel_q, preCnt_q);
  wire logic isFast = (wgm_q[1:0] == 2'b11);
  wire logic isPc = (wgm_q[1:0] == 2'b01);
  wire logic isPwm = wgm_q[0];
  wire logic isClrMatch = (wgm_q == TW_CLR_MATCH);
  wire logic isNormal = (wgm_q == TW_NORMAL);
  wire logic isRsv = (wgm_q == TW_RSV4) || (wgm_q == TW_RSV6);
  wire logic [7:0] topVal = (isPwm && wgm_q[2]) ? cmpA_q : TW_MAX;
  wire logic atTop = (count_q == topVal);
  wire logic atZero = (count_q == TW_BOTTOM);
  wire logic goingUp = atZero || (dirUp_q && !atTop);
  wire logic matchA = (count_q == cmpA_q) && !block_q && !isRsv;
  wire logic matchB = (count_q == cmpB_q) && !block_q && !isRsv;
  wire logic wrCtrl = regWr && (regAddr == TW_OFF_CTRL);
  wire logic wrClk = regWr && (regAddr == TW_OFF_CLK);
  wire logic wrCount = regWr && (regAddr == TW_OFF_COUNT);
  wire logic wrCmpA = regWr && (regAddr == TW_OFF_CMPA);
  wire logic wrCmpB = regWr && (regAddr == TW_OFF_CMPB);
  wire logic wrFlags = regWr && (regAddr == TW_OFF_FLAGS);
  wire logic wrPort = regWr && (regAddr == TW_OFF_PORT);
  wire logic forceA = wrClk && regWrData[TW_CLK_FORCEA_BIT] && !isPwm;
  wire logic forceB = wrClk && regWrData[TW_CLK_FORCEB_BIT] && !isPwm;
  wire logic bufLoad = tick && isPwm && atTop;
  wire logic ovfHit = tick && (((isNormal || isClrMatch) && count_q == TW_MAX)
      || (isFast && atTop)
      || (isPc && atZero && !dirUp_q));
  wire logic toggleOkA = wgm_q[2];
  wire logic connA = (actA_q != 2'd0) && !(isPwm && actA_q == 2'd1 && !toggleOkA);
  wire logic connB = (actB_q != 2'd0) && !(isPwm && actB_q == 2'd1);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    dirUp_d = dirUp_q;
    if (wrCount) begin
      count_d = regWrData;
    end else if (tick) begin
      if (isRsv) begin
        count_d = count_q;
      end else if (isClrMatch) begin
        count_d = (count_q == cmpA_q) ? TW_BOTTOM : 8'(count_q + 8'd1);
      end else if (isFast) begin
        count_d = atTop ? TW_BOTTOM : 8'(count_q + 8'd1);
      end else if (isPc) begin
        dirUp_d = goingUp && !atTop;
        if (goingUp && !atTop) begin
          count_d = 8'(count_q + 8'd1);
        end else if (!goingUp) begin
          count_d = 8'(count_q - 8'd1);
        end
      end else begin
        count_d = 8'(count_q + 8'd1);
      end
    end
  end

  // ------------------------------------------------------------
  // waveforms
  // ------------------------------------------------------------
  wire logic waveA_d = tw_wave_step(waveA_q, actA_q, toggleOkA, isFast, isPc,
      (tick && matchA) || forceA, goingUp, isFast && atTop, isPc && atTop,
      isPc && atZero, cmpA_q == topVal, cmpA_q == TW_BOTTOM);
  wire logic waveB_d = tw_wave_step(waveB_q, actB_q, 1'b0, isFast, isPc,
      (tick && matchB) || forceB, goingUp, isFast && atTop, isPc && atTop,
      isPc && atZero, cmpB_q == topVal, cmpB_q == TW_BOTTOM);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= TW_RST_BYTE;
      dirUp_q <= 1'b1;
      waveA_q <= 1'b0;
      waveB_q <= 1'b0;
      preCnt_q <= 10'h000;
      block_q <= 1'b0;
    end else begin
      count_q <= count_d;
      dirUp_q <= dirUp_d;
      if (tick || forceA) begin
        waveA_q <= waveA_d;
      end
      if (tick || forceB) begin
        waveB_q <= waveB_d;
      end
      preCnt_q <= (clkSel_q == TW_CLK_STOP) ? 10'h000 : 10'(preCnt_q + 10'd1);
      block_q <= wrCount ? 1'b1 : (tick ? 1'b0 : block_q);
    end
  end

  // ------------------------------------------------------------
  // compare values and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cmpA_q <= TW_RST_BYTE;
      cmpB_q <= TW_RST_BYTE;
      bufA_q <= TW_RST_BYTE;
      bufB_q <= TW_RST_BYTE;
      pendA_q <= 1'b0;
      pendB_q <= 1'b0;
      flagA_q <= 1'b0;
      flagB_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wrCmpA) begin
        bufA_q <= regWrData;
      end
      if (wrCmpB) begin
        bufB_q <= regWrData;
      end
      if (wrCmpA && !isPwm) begin
        cmpA_q <= regWrData;
      end else if (bufLoad) begin
        cmpA_q <= bufA_q;
      end
      if (wrCmpB && !isPwm) begin
        cmpB_q <= regWrData;
      end else if (bufLoad) begin
        cmpB_q <= bufB_q;
      end
      if (tick) begin
        pendA_q <= matchA;
        pendB_q <= matchB;
      end
      // a hardware set wins over a clear in the same cycle
      flagA_q <= (tick && pendA_q) || (flagA_q && !(wrFlags && regWrData[TW_FLAG_CMPA_BIT]));
      flagB_q <= (tick && pendB_q) || (flagB_q && !(wrFlags && regWrData[TW_FLAG_CMPB_BIT]));
      ovf_q <= ovfHit || (ovf_q && !(wrFlags && regWrData[TW_FLAG_OVF_BIT]));
    end
  end

  // ------------------------------------------------------------
  // control registers and read port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      actA_q <= 2'b00;
      actB_q <= 2'b00;
      wgm_q <= TW_NORMAL;
      clkSel_q <= TW_CLK_STOP;
      dir_q <= 2'b00;
      portVal_q <= 2'b00;
      rdData_q <= TW_RST_BYTE;
    end else begin
      if (wrCtrl) begin
        actA_q <= regWrData[TW_CTRL_ACTA_LSB +: 2];
        actB_q <= regWrData[TW_CTRL_ACTB_LSB +: 2];
        wgm_q <= regWrData[TW_CTRL_WGM_LSB +: 3];
      end
      if (wrClk) begin
        clkSel_q <= regWrData[TW_CLK_SEL_LSB +: 3];
      end
      if (wrPort) begin
        dir_q <= {regWrData[TW_PORT_DIRB_BIT], regWrData[TW_PORT_DIRA_BIT]};
        portVal_q <= {regWrData[TW_PORT_VALB_BIT], regWrData[TW_PORT_VALA_BIT]};
      end
      if (regRd) begin
        case (regAddr)
          TW_OFF_CTRL: rdData_q <= {actA_q, actB_q, 1'b0, wgm_q};
          TW_OFF_CLK: rdData_q <= {5'b00000, clkSel_q};
          TW_OFF_COUNT: rdData_q <= count_q;
          TW_OFF_CMPA: rdData_q <= bufA_q;
          TW_OFF_CMPB: rdData_q <= bufB_q;
          TW_OFF_FLAGS: rdData_q <= {5'b00000, flagB_q, flagA_q, ovf_q};
          TW_OFF_PORT: rdData_q <= {4'h0, portVal_q, dir_q};
          default: rdData_q <= TW_RST_BYTE;
        endcase
      end else begin
        rdData_q <= TW_RST_BYTE;
      end
    end
  end

  assign regRdData = rdData_q;
  assign waveOutA = connA ? waveA_q : portVal_q[0];
  assign waveOutB = connB ? waveB_q : portVal_q[1];
  assign waveOeA = dir_q[0];
  assign waveOeB = dir_q[1];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_match_clear;
    @(posedge clk) disable iff (rst)
      (tick && isClrMatch && count_q == cmpA_q && !wrCount) |=> (count_q == TW_BOTTOM);
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match mode count not cleared");

  property p_match_ovf;
    @(posedge clk) disable iff (rst)
      (tick && isClrMatch && count_q == TW_MAX && !wrCount) |=> (ovf_q && count_q == TW_BOTTOM);
  endproperty
  a_match_ovf: assert property (p_match_ovf) else $error("match mode overflow missing");

  property p_flag_next_tick;
    @(posedge clk) disable iff (rst)
      (tick && matchA) |=> pendA_q;
  endproperty
  a_flag_next_tick: assert property (p_flag_next_tick) else $error("compare match not held");

  property p_flag_set;
    @(posedge clk) disable iff (rst)
      (tick && pendA_q) |=> flagA_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("compare flag late");

  property p_fast_wrap;
    @(posedge clk) disable iff (rst)
      (tick && isFast && atTop && !wrCount) |=> (count_q == TW_BOTTOM && ovf_q);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong");

  property p_pc_turn;
    @(posedge clk) disable iff (rst)
      (tick && isPc && atTop && !atZero && !wrCount)
      |=> (count_q == 8'($past(count_q) - 8'd1)) && !dirUp_q;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("dual-slope turn wrong");

  property p_pin_dir;
    @(posedge clk) disable iff (rst)
      ##1 (waveOeA == $past(dir_q[0])) || $past(wrPort);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable not from direction");

  property p_div8;
    @(posedge clk) disable iff (rst)
      (tick && clkSel_q == TW_CLK_DIV8 && !wrClk) |=> (!tick) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("prescale by 8 wrong");

  property p_buffer_hold;
    @(posedge clk) disable iff (rst)
      (isPwm && !bufLoad && !wrCtrl) |=> (cmpA_q == $past(cmpA_q));
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("compare bypassed buffer");

  property p_fast_bottom_set;
    @(posedge clk) disable iff (rst)
      (tick && isFast && atTop && actA_q == 2'd2 && cmpA_q != topVal && !forceA)
      |=> waveA_q;
  endproperty
  a_fast_bottom_set: assert property (p_fast_bottom_set) else $error("no set at bottom");

  property p_rsv_hold;
    @(posedge clk) disable iff (rst)
      (isRsv && !wrCount && !wrCtrl) |=> (count_q == $past(count_q));
  endproperty
  a_rsv_hold: assert property (p_rsv_hold) else $error("reserved mode counted");

  property p_pc_ovf;
    @(posedge clk) disable iff (rst)
      (tick && isPc && atZero && !dirUp_q) |=> ovf_q;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("dual-slope overflow missing");

  property p_pc_bottom;
    @(posedge clk) disable iff (rst)
      (tick && isPc && atZero && actA_q == 2'd2 && cmpA_q != TW_BOTTOM)
      |=> waveA_q;
  endproperty
  a_pc_bottom: assert property (p_pc_bottom) else $error("no symmetric set at zero");

endmodule // tw_timer8

// ---- tb/tw_timer8_tb.sv ----
// self-checking bench of the 8-bit waveform timer
`timescale 1ns/1ps
module tb;
  import tw_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic waveOutA;
  logic waveOeA;
  logic waveOutB;
  logic waveOeB;
  int fail_count = 0;
  int cmp_count = 0;
  int hiA;
  int hiB;
  int tgA;
  logic [7:0] rdv;

  always #4 clk = ~clk;

  tw_timer8 dut (
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .waveOutA(waveOutA),
    .waveOeA(waveOeA),
    .waveOutB(waveOutB),
    .waveOeB(waveOeB)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("Counts: %0d mismatches in %0d comparisons", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s gave %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("Error at %0t: %s gave %0d, expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  // stops the counter, loads everything, restarts and lets the buffers settle
  task automatic setup(input tw_mode_type m, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [7:0] ca, input logic [7:0] cb, input logic [2:0] cs,
                       input int settle);
    wr(TW_OFF_CLK, 8'h00);
    wr(TW_OFF_COUNT, 8'h00);
    wr(TW_OFF_CMPA, ca);
    wr(TW_OFF_CMPB, cb);
    wr(TW_OFF_CTRL, {aa, ab, 1'b0, 3'(m)});
    wr(TW_OFF_PORT, 8'h03);
    wr(TW_OFF_FLAGS, 8'h07);
    wr(TW_OFF_CLK, {5'h00, cs});
    repeat (settle) @(negedge clk);
  endtask

  task automatic meas(input int n);
    logic prev;
    hiA = 0;
    hiB = 0;
    tgA = 0;
    prev = waveOutA;
    repeat (n) begin
      @(negedge clk);
      if (waveOutA === 1'b1) hiA++;
      if (waveOutB === 1'b1) hiB++;
      if (waveOutA !== prev) tgA++;
      prev = waveOutA;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] offs [8];
    offs = '{TW_OFF_CTRL, TW_OFF_CLK, TW_OFF_COUNT, TW_OFF_CMPA, TW_OFF_CMPB,
             TW_OFF_FLAGS, TW_OFF_PORT, 8'h1C};
    chk({6'h00, waveOeB, waveOeA}, 8'h00, "enables after reset");
    foreach (offs[i]) begin
      rd(offs[i], rdv);
      chk(rdv, TW_RST_BYTE, "reset value");
    end
  endtask

  task automatic t_clr_match;
    setup(TW_CLR_MATCH, 2'd1, 2'd0, 8'h04, 8'h05, 3'(TW_CLK_STOP), 0);
    wr(TW_OFF_COUNT, 8'h0A);
    wr(TW_OFF_FLAGS, 8'h07);
    wr(TW_OFF_CLK, 8'h01);
    repeat (200) @(negedge clk);
    rd(TW_OFF_FLAGS, rdv);
    chk(rdv, 8'h00, "compare below count not yet met");
    repeat (60) @(negedge clk);
    rd(TW_OFF_FLAGS, rdv);
    chk(rdv, 8'h03, "wrap then match flags");
    meas(100);
    rng(tgA, 19, 21, "ceiling 4 toggles");
    wr(TW_OFF_FLAGS, 8'h07);
    repeat (300) @(negedge clk);
    rd(TW_OFF_FLAGS, rdv);
    chk(rdv, 8'h02, "no overflow below max");
  endtask

  task automatic t_prescale;
    int div [5];
    div = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      setup(TW_CLR_MATCH, 2'd1, 2'd0, 8'h00, 8'h00, 3'(i + 1), 2 * div[i] + 20);
      meas(8 * div[i]);
      rng(tgA, 7, 9, "toggles per divider");
    end
  endtask

  task automatic t_fast;
    setup(TW_FAST_MAX, 2'd2, 2'd2, 8'h40, 8'h80, 3'(TW_CLK_DIV1), 600);
    meas(256);
    rng(hiA, 64, 66, "single-slope A high time");
    rng(hiB, 128, 130, "single-slope B high time");
    rd(TW_OFF_FLAGS, rdv);
    chk(rdv, 8'h07, "single-slope flags");
    setup(TW_FAST_MAX, 2'd3, 2'd3, 8'h40, 8'h80, 3'(TW_CLK_DIV1), 600);
    meas(256);
    rng(hiA, 190, 192, "inverted A high time");
    setup(TW_FAST_MAX, 2'd2, 2'd2, 8'h00, 8'hFF, 3'(TW_CLK_DIV1), 600);
    meas(256);
    rng(hiA, 1, 2, "spike at zero compare");
    rng(hiB, 256, 256, "steady at max compare");
    setup(TW_FAST_A, 2'd1, 2'd0, 8'h09, 8'h00, 3'(TW_CLK_DIV1), 600);
    meas(180);
    rng(tgA, 17, 19, "toggle with ceiling from compare");
    setup(TW_FAST_MAX, 2'd1, 2'd0, 8'h09, 8'h00, 3'(TW_CLK_DIV1), 20);
    wr(TW_OFF_PORT, 8'h07);
    meas(256);
    rng(hiA, 256, 256, "no toggle without high select bit");
  endtask

  task automatic t_dual;
    setup(TW_PC_MAX, 2'd2, 2'd3, 8'h40, 8'h80, 3'(TW_CLK_DIV1), 1100);
    meas(510);
    rng(hiA, 126, 130, "dual-slope A high time");
    rng(hiB, 252, 256, "dual-slope inverted B high time");
    rd(TW_OFF_FLAGS, rdv);
    chk({7'h00, rdv[TW_FLAG_OVF_BIT]}, 8'h01, "dual-slope overflow");
    setup(TW_PC_MAX, 2'd2, 2'd3, 8'h00, 8'hFF, 3'(TW_CLK_DIV1), 1100);
    meas(510);
    rng(hiA, 0, 0, "zero compare low");
    rng(hiB, 0, 0, "inverted max compare low");
    setup(TW_PC_MAX, 2'd3, 2'd2, 8'h00, 8'hFF, 3'(TW_CLK_DIV1), 1100);
    meas(510);
    rng(hiA, 510, 510, "inverted zero compare high");
    rng(hiB, 510, 510, "max compare high");
    setup(TW_PC_A, 2'd1, 2'd0, 8'h09, 8'h00, 3'(TW_CLK_DIV1), 200);
    meas(180);
    rng(tgA, 9, 11, "dual-slope toggle");
  endtask

  task automatic t_pins;
    setup(TW_CLR_MATCH, 2'd0, 2'd0, 8'h04, 8'h04, 3'(TW_CLK_DIV1), 20);
    wr(TW_OFF_PORT, 8'h0F);
    @(negedge clk);
    chk({4'h0, waveOeB, waveOeA, waveOutB, waveOutA}, 8'h0F, "port values out");
    wr(TW_OFF_PORT, 8'h0C);
    @(negedge clk);
    chk({4'h0, waveOeB, waveOeA, waveOutB, waveOutA}, 8'h03, "direction input");
    // forced matches drive the outputs with the counter stopped, flags stay clear
    setup(TW_CLR_MATCH, 2'd3, 2'd2, 8'h04, 8'h04, 3'(TW_CLK_STOP), 0);
    wr(TW_OFF_CLK, 8'hC0);
    @(negedge clk);
    chk({6'h00, waveOutB, waveOutA}, 8'h01, "forced set A clear B");
    setup(TW_CLR_MATCH, 2'd2, 2'd3, 8'h04, 8'h04, 3'(TW_CLK_STOP), 0);
    wr(TW_OFF_CLK, 8'hC0);
    @(negedge clk);
    chk({6'h00, waveOutB, waveOutA}, 8'h02, "forced clear A set B");
    rd(TW_OFF_FLAGS, rdv);
    chk(rdv, 8'h00, "forced match sets no flag");
  endtask

  task automatic t_reserved;
    logic [7:0] first;
    setup(TW_RSV4, 2'd0, 2'd0, 8'h00, 8'h00, 3'(TW_CLK_DIV1), 20);
    rd(TW_OFF_COUNT, first);
    repeat (50) @(negedge clk);
    rd(TW_OFF_COUNT, rdv);
    chk(first, 8'h00, "reserved mode count");
    chk(rdv, 8'h00, "reserved mode count held");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_clr_match();
    t_prescale();
    t_fast();
    t_dual();
    t_pins();
    t_reserved();
    wrap_up();
  end

  initial begin
    #400000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tb
